/* src/phy_mgmt_pkg.sv */
// shared constants, register map and helpers for the management link
package phy_mgmt_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int MDC_HALF_NS   = 80;
	localparam int MDC_HALF_CYC  = (MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLINK_NS      = 50000000;
	localparam int BLINK_CYC     = BLINK_NS / CLK_PERIOD_NS;
	// frame layout
	localparam int         PREAMBLE_LEN = 32;
	localparam int         FRAME_LEN    = 64;
	localparam int         TA_BIT       = 46;
	localparam int         DATA_BIT     = 48;
	localparam logic [1:0] ST_CODE      = 2'h1;
	localparam logic [1:0] OP_READ      = 2'h2;
	localparam logic [1:0] OP_WRITE     = 2'h1;
	localparam logic [1:0] TA_WRITE     = 2'h2;
	localparam logic [1:0] TA_READ      = 2'h3;
	// direct registers
	localparam logic [4:0] REG_PORTAL_CTL   = 5'h0D;
	localparam logic [4:0] REG_PORTAL_DATA  = 5'h0E;
	localparam logic [4:0] REG_INT_CTL_STAT = 5'h1B;
	localparam logic [4:0] REG_CONTROL2     = 5'h1F;
	localparam int         INT_POL_BIT      = 14;
	localparam logic       INT_POL_RST      = 1'h0;
	localparam logic [7:0] INT_EN_RST       = 8'h00;
	// portal
	localparam logic [1:0]  FN_ADDR      = 2'h0;
	localparam int          FN_LSB       = 14;
	localparam logic [4:0]  MMD_SKEW_DEV = 5'h02;
	localparam logic [15:0] MMD_CTL_SKEW = 16'h0004;
	localparam logic [15:0] MMD_RXD_SKEW = 16'h0005;
	localparam logic [15:0] MMD_TXD_SKEW = 16'h0006;
	localparam logic [15:0] MMD_CLK_SKEW = 16'h0008;
	localparam logic [15:0] SKEW_CTL_RST  = 16'h0077;
	localparam logic [15:0] SKEW_DATA_RST = 16'h7777;
	localparam logic [15:0] SKEW_CLK_RST  = 16'h01EF;
	localparam int          CLK_TX_LSB    = 5;
	localparam int          CLK_RX_LSB    = 0;
	localparam int          CTL_RX_LSB    = 4;
	localparam int          CTL_TX_LSB    = 0;
	localparam logic [4:0]  SKEW4_ZERO    = 5'h07;
	localparam logic [4:0]  SKEW5_ZERO    = 5'h0F;
	localparam int          SKEW_STEP_PS  = 60;
	localparam int          RXCLK_BASE_PS = 1200;
	// in-band speed codes
	localparam logic [1:0] SPD_2M5  = 2'h0;
	localparam logic [1:0] SPD_25M  = 2'h1;
	localparam logic [1:0] SPD_125M = 2'h2;
	// controller registers
	localparam logic [2:0] HREG_CMD    = 3'h0;
	localparam logic [2:0] HREG_WDATA  = 3'h1;
	localparam logic [2:0] HREG_STATUS = 3'h2;
	localparam logic [2:0] HREG_RDATA  = 3'h3;
	localparam logic [2:0] HREG_INBAND = 3'h4;
	localparam int         CMD_WR_BIT  = 10;

	// signed delay change in ps for a skew code
	function automatic logic signed [15:0] skew_adj_ps(input logic [4:0] code,
		input logic [4:0] zero);
		logic signed [15:0] diff;
		diff = $signed({11'h000, code}) - $signed({11'h000, zero});
		return 16'(diff * SKEW_STEP_PS);
	endfunction : skew_adj_ps
endpackage : phy_mgmt_pkg

/* src/mgmt_link_if.sv */
// management link, interrupt line and in-band status pins between both ends
`timescale 1ns/1ps
interface mgmt_link_if;
	logic       mdc;
	logic       hostMdioOut;
	logic       hostMdioOe_n;
	logic       phyMdioOut;
	logic       phyMdioOe_n;
	logic       mdio;
	logic       intLine;
	logic       rxDv;
	logic [3:0] rxd;

	// open line with pull-up
	assign mdio = (hostMdioOe_n | hostMdioOut) & (phyMdioOe_n | phyMdioOut);

	modport phy_end (input mdc, input mdio, output phyMdioOut, output phyMdioOe_n,
		output intLine, output rxDv, output rxd);
	modport mac_end (output mdc, input mdio, output hostMdioOut, output hostMdioOe_n,
		input intLine, input rxDv, input rxd);
endinterface : mgmt_link_if

/* src/pin_sync.sv */
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : pin_sync

/* src/phy_mgmt_end.sv */
// transceiver end: management slave, portal, interrupt, in-band status, indicators
// Overview of operation
// (RULE_01) skew codes map linearly, 0.06 ns steps
// (RULE_02) transmit inputs add no delay by default
// (RULE_03) receive clock lags data about 1.2 ns
// (RULE_04) portal: device number, then register index
// (RULE_05) data function then reaches extended register
// (RULE_06) 0x03FF sets both clock skews maximum
// (RULE_07) in-band status whenever data-valid is low
// (RULE_08) in-band bits: duplex, clock rate, link
// (RULE_09) answer only strapped address, upper bits zero
// (RULE_10) address zero is no broadcast
// (RULE_11) frame: preamble, start, opcode, addresses, turnaround, data
// (RULE_12) thirty-two direct registers decoded
// (RULE_13) enabled status condition asserts interrupt
// (RULE_14) reading status register clears all flags
// (RULE_15) interrupt polarity selectable, active low default
// (RULE_16) indicator scheme strap latched at reset
// (RULE_17) controller writes each transceiver separately
// (RULE_18) clock skews in extended register eight
// (RULE_19) control skews in extended register four
// (RULE_20) sample on rising edge, drive only read
// (RULE_21) interrupt holds until enabled flags cleared
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module phy_mgmt_end
	import phy_mgmt_pkg::*;
#(
	parameter int BLINK_DIV = BLINK_CYC
) (
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	// link
	mgmt_link_if.phy_end            link,
	// straps
	input  wire logic [2:0]         station_addr_strap,
	input  wire logic               indicator_scheme_strap,
	// line status and receive frames
	input  wire logic               linkUp,
	input  wire logic               fullDuplex,
	input  wire logic [1:0]         speed,
	input  wire logic               activity,
	input  wire logic               frameValid,
	input  wire logic [3:0]         frameData,
	input  wire logic [7:0]         intEvents,
	// indicators
	output logic                    indicator_a,
	output logic                    indicator_b,
	// pad skew configuration
	output logic signed [15:0]      txClkAdjPs,
	output logic signed [15:0]      rxClkDelayPs,
	output logic signed [15:0]      txCtlAdjPs,
	output logic signed [15:0]      rxCtlAdjPs,
	output logic [15:0]             rxDataSkew,
	output logic [15:0]             txDataSkew
);
	typedef enum logic [1:0] {S_PRE, S_HDR, S_TA, S_DATA} slv_state_t;

	slv_state_t  state_r;
	logic [1:0]  pinS;
	logic        mdcD_r;
	logic        rise;
	logic        fall;
	logic        bitIn;
	logic [5:0]  ones_r;
	logic [3:0]  cnt_r;
	logic [11:0] hdr_r;
	logic [12:0] hdrAll;
	logic        hdrOk;
	logic        isRead_r;
	logic        hit_r;
	logic [4:0]  regAddr_r;
	logic [15:0] wdata_r;
	logic [15:0] rdData_r;
	logic [15:0] readVal;
	logic        hdrDone;
	logic        rdClear;
	logic        wrStb;
	logic [15:0] wrVal;
	logic [2:0]  addr_r;
	logic        scheme_r;
	logic [15:0] portalCtl_r;
	logic [15:0] mmdIdx_r;
	logic [15:0] skewCtl_r;
	logic [15:0] skewRxd_r;
	logic [15:0] skewTxd_r;
	logic [15:0] skewClk_r;
	logic [7:0]  intEn_r;
	logic [7:0]  intStat_r;
	logic        intPol_r;
	logic [31:0] blinkCnt_r;
	logic        blink_r;

	pin_sync #(.W(2)) u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.d       ({link.mdc, link.mdio}),
		.q       (pinS)
	);

	// mdc edges found from the synchronised copy only
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			mdcD_r <= 1'h0;
		else
			mdcD_r <= pinS[1];
	end
	assign rise  = pinS[1] & ~mdcD_r; // RULE_20
	assign fall  = ~pinS[1] & mdcD_r;
	assign bitIn = pinS[0];

	// straps caught while reset is held
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			addr_r   <= station_addr_strap; // RULE_09
			scheme_r <= indicator_scheme_strap; // RULE_16
		end
	end

	assign hdrAll  = {hdr_r, bitIn};
	assign hdrOk   = hdrAll[12] && (hdrAll[11:10] == OP_READ || hdrAll[11:10] == OP_WRITE);
	assign hdrDone = rise && state_r == S_HDR && cnt_r == 4'hC;
	// no broadcast address: only the strapped one matches
	assign rdClear = hdrDone && hdrOk && hdrAll[11:10] == OP_READ && hdrAll[9:8] == 2'h0
		&& hdrAll[7:5] == addr_r && hdrAll[4:0] == REG_INT_CTL_STAT; // RULE_14
	assign wrStb   = rise && state_r == S_DATA && cnt_r == 4'hF && !isRead_r && hit_r;
	assign wrVal   = {wdata_r[14:0], bitIn};

	// frame decoder
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_r   <= S_PRE;
			ones_r    <= '0;
			cnt_r     <= '0;
			hdr_r     <= '0;
			isRead_r  <= 1'h0;
			hit_r     <= 1'h0;
			regAddr_r <= '0;
			wdata_r   <= '0;
		end else if (rise) begin
			unique case (state_r)
				S_PRE: begin
					if (bitIn)
						ones_r <= (ones_r == 6'(PREAMBLE_LEN)) ? ones_r : ones_r + 6'h1;
					else if (ones_r == 6'(PREAMBLE_LEN)) begin // RULE_11
						state_r <= S_HDR;
						cnt_r   <= '0;
					end else
						ones_r <= '0;
				end
				S_HDR: begin
					hdr_r <= hdrAll[11:0];
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == 4'hC) begin
						ones_r    <= '0;
						cnt_r     <= '0;
						state_r   <= hdrOk ? S_TA : S_PRE;
						isRead_r  <= hdrAll[11:10] == OP_READ;
						hit_r     <= hdrAll[9:8] == 2'h0 && hdrAll[7:5] == addr_r; // RULE_09 RULE_10
						regAddr_r <= hdrAll[4:0];
					end
				end
				S_TA: begin
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == 4'h1) begin
						state_r <= S_DATA;
						cnt_r   <= '0;
					end
				end
				S_DATA: begin
					wdata_r <= wrVal;
					cnt_r   <= cnt_r + 4'h1;
					if (cnt_r == 4'hF)
						state_r <= S_PRE;
				end
			endcase
		end
	end

	// read mux over all 32 direct addresses; unlisted ones read zero
	always_comb begin
		readVal = '0;
		unique case (hdrAll[4:0]) // RULE_12
			REG_PORTAL_CTL:   readVal = portalCtl_r;
			REG_PORTAL_DATA: begin
				if (portalCtl_r[15:FN_LSB] == FN_ADDR)
					readVal = mmdIdx_r;
				else if (portalCtl_r[4:0] == MMD_SKEW_DEV) begin // RULE_05
					unique case (mmdIdx_r)
						MMD_CTL_SKEW: readVal = skewCtl_r;
						MMD_RXD_SKEW: readVal = skewRxd_r;
						MMD_TXD_SKEW: readVal = skewTxd_r;
						MMD_CLK_SKEW: readVal = skewClk_r;
						default:      readVal = '0;
					endcase
				end
			end
			REG_INT_CTL_STAT: readVal = {intEn_r, intStat_r};
			REG_CONTROL2:     readVal = 16'(intPol_r) << INT_POL_BIT;
			default:          readVal = '0;
		endcase
	end

	// read data frozen at header end
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			rdData_r <= '0;
		else if (hdrDone)
			rdData_r <= readVal;
	end

	// data line: released except second turnaround bit and read data
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			link.phyMdioOut  <= 1'h1;
			link.phyMdioOe_n <= 1'h1;
		end else if (fall) begin
			if (state_r == S_TA && cnt_r == 4'h1 && isRead_r && hit_r) begin // RULE_20
				link.phyMdioOut  <= 1'h0;
				link.phyMdioOe_n <= 1'h0;
			end else if (state_r == S_DATA && isRead_r && hit_r) begin
				link.phyMdioOut  <= rdData_r[4'hF - cnt_r];
				link.phyMdioOe_n <= 1'h0;
			end else begin
				link.phyMdioOut  <= 1'h1;
				link.phyMdioOe_n <= 1'h1;
			end
		end
	end

	// direct and portal register writes
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			portalCtl_r <= '0;
			mmdIdx_r    <= '0;
			skewCtl_r   <= SKEW_CTL_RST; // RULE_19 RULE_02
			skewRxd_r   <= SKEW_DATA_RST;
			skewTxd_r   <= SKEW_DATA_RST;
			skewClk_r   <= SKEW_CLK_RST; // RULE_18 RULE_03
			intEn_r     <= INT_EN_RST;
			intPol_r    <= INT_POL_RST; // RULE_15
		end else if (wrStb) begin
			unique case (regAddr_r)
				REG_PORTAL_CTL: portalCtl_r <= wrVal; // RULE_04
				REG_PORTAL_DATA: begin
					if (portalCtl_r[15:FN_LSB] == FN_ADDR)
						mmdIdx_r <= wrVal; // RULE_04
					else if (portalCtl_r[4:0] == MMD_SKEW_DEV) begin // RULE_05
						unique case (mmdIdx_r)
							MMD_CTL_SKEW: skewCtl_r <= wrVal;
							MMD_RXD_SKEW: skewRxd_r <= wrVal;
							MMD_TXD_SKEW: skewTxd_r <= wrVal;
							MMD_CLK_SKEW: skewClk_r <= wrVal; // RULE_06
							default: ;
						endcase
					end
				end
				REG_INT_CTL_STAT: intEn_r  <= wrVal[15:8]; // RULE_13
				REG_CONTROL2:     intPol_r <= wrVal[INT_POL_BIT];
				default: ;
			endcase
		end
	end

	// sticky flags; an event in the clearing cycle survives
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			intStat_r <= '0;
		else
			intStat_r <= (rdClear ? 8'h00 : intStat_r) | intEvents; // RULE_14
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			link.intLine <= ~INT_POL_RST;
		else
			link.intLine <= (|(intEn_r & intStat_r)) ~^ intPol_r; // RULE_13 RULE_15 RULE_21
	end

	// in-band status fills the gap between frames, no setup needed
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			link.rxDv <= 1'h0;
			link.rxd  <= '0;
		end else begin
			link.rxDv <= frameValid;
			link.rxd  <= frameValid ? frameData : {fullDuplex, speed, linkUp}; // RULE_07 RULE_08
		end
	end

	// blink phase for activity
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			blinkCnt_r <= '0;
			blink_r    <= 1'h0;
		end else if (blinkCnt_r == 32'(BLINK_DIV - 1)) begin
			blinkCnt_r <= '0;
			blink_r    <= ~blink_r;
		end else
			blinkCnt_r <= blinkCnt_r + 32'h1;
	end

	// indicators are low when lit
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			indicator_a <= 1'h1;
			indicator_b <= 1'h1;
		end else if (scheme_r) begin // RULE_16
			indicator_b <= ~linkUp;
			indicator_a <= ~(linkUp & activity & blink_r);
		end else begin
			indicator_b <= ~(linkUp && speed != SPD_25M && !(activity && blink_r));
			indicator_a <= ~(linkUp && speed != SPD_125M && !(activity && blink_r));
		end
	end

	// delay figures the pad cells would apply
	assign txClkAdjPs   = skew_adj_ps(skewClk_r[CLK_TX_LSB +: 5], SKEW5_ZERO); // RULE_01 RULE_02
	assign rxClkDelayPs = 16'(RXCLK_BASE_PS)
		+ skew_adj_ps(skewClk_r[CLK_RX_LSB +: 5], SKEW5_ZERO); // RULE_03
	assign txCtlAdjPs   = skew_adj_ps({1'h0, skewCtl_r[CTL_TX_LSB +: 4]}, SKEW4_ZERO); // RULE_01
	assign rxCtlAdjPs   = skew_adj_ps({1'h0, skewCtl_r[CTL_RX_LSB +: 4]}, SKEW4_ZERO);
	assign rxDataSkew   = skewRxd_r;
	assign txDataSkew   = skewTxd_r;
endmodule : phy_mgmt_end

/* src/mac_mgmt_end.sv */
// controller end: frames management commands, watches interrupt and in-band status
`timescale 1ns/1ps
module mac_mgmt_end
	import phy_mgmt_pkg::*;
#(
	parameter int MDC_HALF = MDC_HALF_CYC
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// link
	mgmt_link_if.mac_end     link,
	// software port
	input  wire logic [2:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdata
);
	typedef enum logic {H_IDLE, H_RUN} host_state_t;

	host_state_t state_r;
	logic [5:0]  pinS;
	logic [7:0]  half_r;
	logic [5:0]  bitIdx_r;
	logic [63:0] frame_r;
	logic        isRead_r;
	logic [15:0] wdata_r;
	logic [15:0] rdata_r;
	logic [15:0] rdShift_r;
	logic        done_r;
	logic [3:0]  inband_r;
	logic        tick;
	logic        start;
	logic        finish;

	pin_sync #(.W(6)) u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.d       ({link.mdio, link.intLine, link.rxDv, link.rxd[2:0]}),
		.q       (pinS)
	);

	logic [3:0] rxdS;
	logic       rxd3Meta_r;
	logic       rxd3S_r;
	// rxd3 gets its own pair; one driver per variable keeps the word whole
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rxd3Meta_r <= 1'h0;
			rxd3S_r    <= 1'h0;
		end else begin
			rxd3Meta_r <= link.rxd[3];
			rxd3S_r    <= rxd3Meta_r;
		end
	end
	assign rxdS = {rxd3S_r, pinS[2:0]};

	// one frame at a time; a command while busy is dropped
	assign start  = regWr && regAddr == HREG_CMD && state_r == H_IDLE;
	assign tick   = state_r == H_RUN && half_r == 8'(MDC_HALF - 1);
	assign finish = tick && link.mdc && bitIdx_r == 6'(FRAME_LEN - 1);

	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			wdata_r <= '0;
		else if (regWr && regAddr == HREG_WDATA)
			wdata_r <= regWdata;
	end

	// frame engine: mdc low half then high half per bit
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_r           <= H_IDLE;
			half_r            <= '0;
			bitIdx_r          <= '0;
			frame_r           <= '0;
			isRead_r          <= 1'h0;
			rdShift_r         <= '0;
			link.mdc          <= 1'h0;
			link.hostMdioOut  <= 1'h1;
			link.hostMdioOe_n <= 1'h1;
		end else if (start) begin // RULE_17
			state_r           <= H_RUN;
			half_r            <= '0;
			bitIdx_r          <= '0;
			isRead_r          <= ~regWdata[CMD_WR_BIT];
			frame_r           <= {{PREAMBLE_LEN{1'h1}}, ST_CODE,
				regWdata[CMD_WR_BIT] ? OP_WRITE : OP_READ, regWdata[9:0],
				regWdata[CMD_WR_BIT] ? TA_WRITE : TA_READ,
				regWdata[CMD_WR_BIT] ? wdata_r : 16'hFFFF}; // RULE_11
			link.hostMdioOut  <= 1'h1;
			link.hostMdioOe_n <= 1'h0;
		end else if (state_r == H_RUN) begin
			half_r <= tick ? 8'h00 : half_r + 8'h01;
			if (tick && !link.mdc) begin
				link.mdc <= 1'h1;
				if (isRead_r && bitIdx_r >= 6'(DATA_BIT))
					rdShift_r <= {rdShift_r[14:0], pinS[5]};
			end else if (tick) begin
				link.mdc <= 1'h0;
				bitIdx_r <= bitIdx_r + 6'h01;
				frame_r  <= {frame_r[62:0], 1'h1};
				if (finish) begin
					state_r           <= H_IDLE;
					link.hostMdioOut  <= 1'h1;
					link.hostMdioOe_n <= 1'h1;
				end else begin
					link.hostMdioOut  <= frame_r[62];
					link.hostMdioOe_n <= isRead_r && bitIdx_r + 6'h01 >= 6'(TA_BIT);
				end
			end
		end
	end

	// read word taken from the shift register when a read frame ends
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			rdata_r <= '0;
		else if (finish && isRead_r)
			rdata_r <= rdShift_r;
	end

	// done is sticky; set wins over the clearing read
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			done_r <= 1'h0;
		else
			done_r <= finish | (done_r & ~(regRd && regAddr == HREG_STATUS));
	end

	// in-band status is only meaningful outside frames
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			inband_r <= '0;
		else if (!pinS[3])
			inband_r <= rxdS;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			regRdata <= '0;
		else if (regRd) begin
			unique case (regAddr)
				HREG_STATUS: regRdata <= {13'h0000, pinS[4], done_r, state_r == H_RUN};
				HREG_RDATA:  regRdata <= rdata_r;
				HREG_INBAND: regRdata <= {12'h000, inband_r};
				HREG_WDATA:  regRdata <= wdata_r;
				default:     regRdata <= '0;
			endcase
		end else
			regRdata <= '0;
	end
endmodule : mac_mgmt_end

/* tb/phy_mgmt_monitor.sv */
// concurrent checks on the management link between both ends
`timescale 1ns/1ps
module phy_mgmt_monitor #(
	parameter int MDC_HALF = 10
) (
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_n,
	// link
	input wire logic       mdc,
	input wire logic       hostMdioOut,
	input wire logic       hostMdioOe_n,
	input wire logic       phyMdioOut,
	input wire logic       phyMdioOe_n,
	input wire logic       intLine,
	input wire logic       rxDv,
	input wire logic [3:0] rxd
);
	logic [9:0] hiCnt_r;
	logic [9:0] drvCnt_r;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// counts sampled cycles of mdc high and of phy driving
	always_ff @(posedge ref_clk) begin
		hiCnt_r <= (rst_n && mdc) ? hiCnt_r + 10'h001 : 10'h000;
	end
	always_ff @(posedge ref_clk) begin
		drvCnt_r <= (rst_n && !phyMdioOe_n) ? drvCnt_r + 10'h001 : 10'h000;
	end

	property p_no_clash;
		!(!hostMdioOe_n && !phyMdioOe_n);
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("both ends drive the data line");
	property p_preamble;
		$fell(hostMdioOe_n) |-> hostMdioOut [*8];
	endproperty
	a_preamble: assert property (p_preamble) else $error("frame does not open with ones");
	property p_mdc_high;
		$fell(mdc) |-> hiCnt_r == 10'(MDC_HALF);
	endproperty
	a_mdc_high: assert property (p_mdc_high) else $error("clock high phase has wrong length");
	property p_host_bit;
		$changed(hostMdioOut) |-> !mdc;
	endproperty
	a_host_bit: assert property (p_host_bit) else $error("host data moved while clock high");
	property p_ta_zero;
		$fell(phyMdioOe_n) |-> !phyMdioOut && hostMdioOe_n;
	endproperty
	a_ta_zero: assert property (p_ta_zero) else $error("turnaround not a driven zero");
	property p_phy_hold;
		$fell(phyMdioOe_n) |-> !phyMdioOe_n [*8];
	endproperty
	a_phy_hold: assert property (p_phy_hold) else $error("phy released the line too early");
	property p_phy_bit;
		$changed(phyMdioOut) && !phyMdioOe_n |-> !mdc;
	endproperty
	a_phy_bit: assert property (p_phy_bit) else $error("phy data moved while clock high");
	property p_phy_release;
		drvCnt_r <= 10'(34 * MDC_HALF + 8);
	endproperty
	a_phy_release: assert property (p_phy_release) else $error("phy kept the line too long");
	property p_int_reset;
		$rose(rst_n) |-> intLine;
	endproperty
	a_int_reset: assert property (p_int_reset) else $error("interrupt active out of reset");
	property p_inband;
		!rxDv |-> rxd[2:1] != 2'h3;
	endproperty
	a_inband: assert property (p_inband) else $error("reserved clock rate code sent");

	c_read_drive: cover property ($fell(phyMdioOe_n));
	c_int_change: cover property ($changed(intLine));
	c_frame_data: cover property ($rose(rxDv));
endmodule : phy_mgmt_monitor

/* tb/testbench.sv */
// both management ends joined, driven through the software port and line inputs
`timescale 1ns/1ps
module testbench;
	import phy_mgmt_pkg::*;
	logic               ref_clk;
	logic               rst_n;
	logic [2:0]         strap;
	logic               scheme;
	logic               linkUp;
	logic               fullDuplex;
	logic [1:0]         speed;
	logic               activity;
	logic               frameValid;
	logic [3:0]         frameData;
	logic [7:0]         intEvents;
	logic               indA;
	logic               indB;
	logic signed [15:0] txClkAdj;
	logic signed [15:0] rxClkDly;
	logic signed [15:0] txCtlAdj;
	logic signed [15:0] rxCtlAdj;
	logic [15:0]        rxDataSkew;
	logic [15:0]        txDataSkew;
	logic [2:0]         regAddr;
	logic [15:0]        regWdata;
	logic               regWr;
	logic               regRd;
	logic [15:0]        regRdata;
	int                 numErrors = 0;
	int                 numChecks = 0;
	int                 rises = 0;
	localparam logic [4:0] PH = 5'h05;

	mgmt_link_if link ();
	phy_mgmt_end #(.BLINK_DIV(4)) i_phy_mgmt_end (.ref_clk(ref_clk), .rst_n(rst_n),
		.link(link), .station_addr_strap(strap), .indicator_scheme_strap(scheme),
		.linkUp(linkUp), .fullDuplex(fullDuplex), .speed(speed), .activity(activity),
		.frameValid(frameValid), .frameData(frameData), .intEvents(intEvents),
		.indicator_a(indA), .indicator_b(indB), .txClkAdjPs(txClkAdj),
		.rxClkDelayPs(rxClkDly), .txCtlAdjPs(txCtlAdj), .rxCtlAdjPs(rxCtlAdj),
		.rxDataSkew(rxDataSkew), .txDataSkew(txDataSkew));
	mac_mgmt_end #(.MDC_HALF(10)) i_mac_mgmt_end (.ref_clk(ref_clk), .rst_n(rst_n),
		.link(link), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata));
	phy_mgmt_monitor #(.MDC_HALF(10)) mon (.ref_clk(ref_clk), .rst_n(rst_n),
		.mdc(link.mdc), .hostMdioOut(link.hostMdioOut), .hostMdioOe_n(link.hostMdioOe_n),
		.phyMdioOut(link.phyMdioOut), .phyMdioOe_n(link.phyMdioOe_n),
		.intLine(link.intLine), .rxDv(link.rxDv), .rxd(link.rxd));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge link.mdc) rises++;

	task automatic wrapUp();
		$display("checks %0d mismatches %0d", numChecks, numErrors);
		if (numErrors == 0 && numChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrapUp
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		numChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		@(negedge ref_clk);
		d = regRdata;
	endtask : rd
	// one frame; the result word is meaningful for reads only
	task automatic mii(input logic w, input logic [4:0] ph, input logic [4:0] rg,
		input logic [15:0] d, output logic [15:0] q);
		int n;
		logic [15:0] s;
		n = 0;
		s = 16'h0000;
		wr(HREG_WDATA, d);
		wr(HREG_CMD, {5'h00, w, ph, rg});
		while (s[1] !== 1'b1) begin
			rd(HREG_STATUS, s);
			n++;
			if (n > 1000) begin
				numErrors++;
				$display("CHECK FAILED at %0t got %h expected %h", $time, s, 16'h0002);
				wrapUp();
			end
		end
		rd(HREG_RDATA, q);
	endtask : mii
	task automatic mmd(input logic [15:0] idx);
		logic [15:0] q;
		mii(1'b1, PH, REG_PORTAL_CTL, {11'h000, MMD_SKEW_DEV}, q);
		mii(1'b1, PH, REG_PORTAL_DATA, idx, q);
		mii(1'b1, PH, REG_PORTAL_CTL, 16'h4002, q);
	endtask : mmd
	task automatic pulse(input logic [7:0] e);
		@(posedge ref_clk);
		intEvents <= e;
		@(posedge ref_clk);
		intEvents <= 8'h00;
		repeat (4) @(posedge ref_clk);
	endtask : pulse
	// straps are sampled while reset is low, so they settle first
	task automatic do_reset();
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask : do_reset

	initial begin
		logic [15:0] q;
		{rst_n, regWr, regRd, regAddr, regWdata, intEvents} = '0;
		{linkUp, fullDuplex, speed, activity, frameValid, frameData} = '0;
		strap = 3'h5;
		scheme = 1'b1;
		do_reset();
		chk(txClkAdj, 16'h0000);
		chk(rxClkDly, 16'h04B0);
		chk(txCtlAdj | rxCtlAdj, 16'h0000);
		chk(rxDataSkew & txDataSkew, 16'h7777);
		$display("defaults done");
		rises = 0;
		mii(1'b0, PH, 5'h10, 16'h0000, q);
		chk(q, 16'h0000);
		chk(16'(rises), 16'h0040);
		chk({14'h0000, link.mdc, link.mdio}, 16'h0001);
		mii(1'b0, 5'h0D, REG_INT_CTL_STAT, 16'h0000, q);
		chk(q, 16'hFFFF);
		mii(1'b0, 5'h04, REG_INT_CTL_STAT, 16'h0000, q);
		chk(q, 16'hFFFF);
		mii(1'b1, 5'h00, REG_INT_CTL_STAT, 16'hFF00, q);
		mii(1'b0, PH, REG_INT_CTL_STAT, 16'h0000, q);
		chk(q, 16'h0000);
		rd(3'h7, q);
		chk(q, 16'h0000);
		$display("addressing done");
		mmd(MMD_CLK_SKEW);
		mii(1'b0, PH, REG_PORTAL_DATA, 16'h0000, q);
		chk(q, 16'h01EF);
		mii(1'b1, PH, REG_PORTAL_DATA, 16'h03FF, q);
		mii(1'b0, PH, REG_PORTAL_DATA, 16'h0000, q);
		chk(q, 16'h03FF);
		chk(txClkAdj, 16'h03C0);
		chk(rxClkDly, 16'h0870);
		mmd(MMD_CTL_SKEW);
		mii(1'b0, PH, REG_PORTAL_DATA, 16'h0000, q);
		chk(q, 16'h0077);
		mii(1'b1, PH, REG_PORTAL_DATA, 16'h00F0, q);
		chk(rxCtlAdj, 16'h01E0);
		chk(txCtlAdj, 16'hFE5C);
		$display("portal done");
		pulse(8'h02);
		chk({15'h0000, link.intLine}, 16'h0001);
		mii(1'b0, PH, REG_INT_CTL_STAT, 16'h0000, q);
		chk(q, 16'h0002);
		mii(1'b1, PH, REG_INT_CTL_STAT, 16'h0100, q);
		pulse(8'h01);
		chk({15'h0000, link.intLine}, 16'h0000);
		mii(1'b0, PH, REG_INT_CTL_STAT, 16'h0000, q);
		chk(q, 16'h0101);
		chk({15'h0000, link.intLine}, 16'h0001);
		mii(1'b0, PH, REG_INT_CTL_STAT, 16'h0000, q);
		chk(q, 16'h0100);
		mii(1'b1, PH, REG_CONTROL2, 16'h4000, q);
		chk({15'h0000, link.intLine}, 16'h0000);
		pulse(8'h01);
		chk({15'h0000, link.intLine}, 16'h0001);
		rd(HREG_STATUS, q);
		chk(q & 16'h0004, 16'h0004);
		$display("interrupt done");
		for (int s = 0; s < 3; s++) begin
			@(posedge ref_clk);
			speed <= 2'(s);
			linkUp <= (s != 1);
			fullDuplex <= (s == 1);
			repeat (3) @(posedge ref_clk);
			chk({11'h000, link.rxDv, link.rxd}, {12'h000, fullDuplex, speed, linkUp});
			rd(HREG_INBAND, q);
			chk(q, {12'h000, fullDuplex, speed, linkUp});
		end
		@(posedge ref_clk);
		frameValid <= 1'b1;
		frameData <= 4'hA;
		repeat (3) @(posedge ref_clk);
		chk({11'h000, link.rxDv, link.rxd}, 16'h001A);
		frameValid <= 1'b0;
		$display("in-band done");
		speed <= SPD_25M;
		linkUp <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk({14'h0000, indA, indB}, 16'h0002);
		scheme <= 1'b0;
		do_reset();
		scheme <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk({14'h0000, indA, indB}, 16'h0001);
		chk(txClkAdj, 16'h0000);
		speed <= SPD_2M5;
		repeat (4) @(posedge ref_clk);
		chk({14'h0000, indA, indB}, 16'h0000);
		$display("indicators done");
		wrapUp();
	end
endmodule : testbench
